// >>> inc/pts_pkg.sv
/*
  Shared constants, carrier types and helpers for the pattern trigger and
  peer sync pin logic.
  Assumes one 25 MHz core clock; every pin is asynchronous to it.
*/
package pts_pkg;

  // core clock
  localparam int CLK_PERIOD_NS = 40;

  // sequence align low pulse, a least time so it rounds up
  localparam int ALIGN_PULSE_NS = 400;
  localparam int ALIGN_PULSE_CYCLES =
    (ALIGN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // frame timing high pulse, a least time so it rounds up
  localparam int FRAME_PULSE_NS = 400;
  localparam int FRAME_PULSE_CYCLES =
    (FRAME_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // frame period, a longest time so it rounds down
  localparam int FRAME_PERIOD_US = 16667;
  localparam int FRAME_PERIOD_CYCLES =
    (FRAME_PERIOD_US * 1000) / CLK_PERIOD_NS;

  // widths of the steering inputs and the align counter
  localparam int PWM_WIDTH = 8;
  localparam int INDEX_WIDTH = 8;
  localparam int EXPOSE_WIDTH = 24;
  localparam int ALIGN_CNT_WIDTH = 8;

  // colour lane positions inside a duty vector
  localparam int LANE_BLUE = 0;
  localparam int LANE_GREEN = 1;
  localparam int LANE_RED = 2;
  localparam int LANES = 3;

  // sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_EXPOSE,
    ST_WAIT
  } pts_state_e;

  // one bit per light source
  typedef struct packed {
    logic red;
    logic green;
    logic blue;
  } pts_rgb_s;

  localparam pts_rgb_s RGB_OFF = '{red: 1'b0, green: 1'b0, blue: 1'b0};

  // pwm duty per lane
  typedef logic [LANES-1:0][PWM_WIDTH-1:0] pts_duty_t;

  // asynchronous pin inputs, carried together through the synchroniser
  typedef struct packed {
    logic advance;
    logic run;
    logic role;
    logic peerPresent;
    logic seqAlign;
    logic frameTiming;
  } pts_pins_s;

  localparam pts_pins_s PINS_RESET = '0;

  // edge helpers used on several synchronised pins
  function automatic logic pts_rise(input logic cur, input logic prev);
    return cur & ~prev;
  endfunction : pts_rise

  function automatic logic pts_fall(input logic cur, input logic prev);
    return ~cur & prev;
  endfunction : pts_fall

endpackage : pts_pkg

// >>> hdl/pts_sync.sv
/*
  Two-flop synchroniser for a vector of independent pin levels.
  Assumes each bit is a slow level; bits are not coherent with each other.
*/
`timescale 1ns/100ps
`default_nettype none

module pts_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async,
  output logic [WIDTH-1:0] synced
);

  logic [WIDTH-1:0] stage1;

  // first stage is read only by the second stage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage1 <= RESET_VALUE;
      synced <= RESET_VALUE;
    end else begin
      stage1 <= async;
      synced <= stage1;
    end
  end

endmodule : pts_sync

`default_nettype wire

// >>> hdl/pts_pwm.sv
/*
  Free-running pwm generator for one light-source current lane.
  Assumes the duty value is stable logic on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none

module pts_pwm #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic [WIDTH-1:0] duty,
  output logic pwm
);

  logic [WIDTH-1:0] phase;

  // period is 2**WIDTH cycles; duty of all ones never quite reaches 100%
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase <= '0;
    end else begin
      phase <= phase + 1'b1;
    end
  end

  // output low whenever the lane is disabled
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pwm <= 1'b0;
    end else begin
      pwm <= enable && (phase < duty);
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  chk_pwm_gate: assert property (!enable |=> !pwm)
    else $error("pwm high while lane disabled");

endmodule : pts_pwm

`default_nettype wire

// >>> hdl/pts_io_top.sv
/*
  Pattern trigger, light-source and two-controller sync pin logic.
  Assumes the sequencing firmware side drives the steering inputs on clk;
  all pins arrive asynchronously and open-drain wires resolve outside.
*/
// Functional notes
// - advance trigger steps the pattern sequence
// - run trigger rising edge starts display
// - run trigger falling edge stops display
// - software start/stop also controls running
// - exposure output high during pattern exposure
// - first pattern output marks first pattern
// - per-colour pwm sets source current
// - per-colour enables switch sources
// - secondary keeps trigger and source pins idle
// - role select high means primary
// - secondary flags presence high; primary reads it
// - primary drives peer serial chip select
// - shared sequence align line keeps sequences aligned
// - primary frame timing feeds both controllers
// - secondary leaves frame timing output undriven
`timescale 1ns/100ps
`default_nettype none

module pts_io_top
  import pts_pkg::*;
#(
  parameter int unsigned FRAME_CYCLES = FRAME_PERIOD_CYCLES,
  parameter int INDEX_W = INDEX_WIDTH,
  parameter int EXPOSE_W = EXPOSE_WIDTH,
  parameter int PWM_W = PWM_WIDTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic patternAdvanceIn,
  input wire logic patternRunIn,
  input wire logic roleSelect,
  input wire logic peerPresentIn,
  input wire logic sequenceAlignIn,
  input wire logic frameTimingIn,
  input wire logic videoPatternMode,
  input wire logic swStartCmd,
  input wire logic swStopCmd,
  input wire logic selfReady,
  input wire logic peerSelectReq,
  input wire logic [INDEX_W-1:0] patternCount,
  input wire logic [EXPOSE_W-1:0] exposureCycles,
  input wire pts_rgb_s sourceMask,
  input wire logic [LANES-1:0][PWM_W-1:0] sourceDuty,
  output logic exposureActiveOut,
  output logic firstPatternOut,
  output logic redSourcePwm,
  output logic greenSourcePwm,
  output logic blueSourcePwm,
  output logic redSourceEnable,
  output logic greenSourceEnable,
  output logic blueSourceEnable,
  output logic peerPresentOut,
  output logic peerPresentOe,
  output logic peerSerialSelectN,
  output logic peerSerialSelectOe,
  output logic sequenceAlignOut,
  output logic sequenceAlignOe,
  output logic frameTimingOut,
  output logic frameTimingOe,
  output logic isPrimary,
  output logic peerReady,
  output logic [INDEX_W-1:0] patternIndex,
  output logic sequenceRestart,
  output logic frameTick
);

  localparam int FRAME_W = $clog2(FRAME_CYCLES + 1);
  localparam logic [FRAME_W-1:0] FRAME_LAST = FRAME_W'(FRAME_CYCLES - 1);
  localparam logic [FRAME_W-1:0] FRAME_HIGH = FRAME_W'(FRAME_PULSE_CYCLES);
  localparam logic [ALIGN_CNT_WIDTH-1:0] ALIGN_LOAD =
    ALIGN_CNT_WIDTH'(ALIGN_PULSE_CYCLES);

  pts_pins_s pinsAsync;
  pts_pins_s pinsSync;
  pts_pins_s pinsPrev;
  pts_state_e state;
  pts_state_e next_state;
  logic [INDEX_W-1:0] next_index;
  logic [EXPOSE_W-1:0] exposeCnt;
  logic [ALIGN_CNT_WIDTH-1:0] alignCnt;
  logic [FRAME_W-1:0] frameCnt;
  logic runFlag;
  logic advRise;
  logic runRise;
  logic runFall;
  logic goNow;
  logic startExpose;
  pts_rgb_s lampOn;

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers and edge detection

  assign pinsAsync = '{advance: patternAdvanceIn, run: patternRunIn,
                       role: roleSelect, peerPresent: peerPresentIn,
                       seqAlign: sequenceAlignIn,
                       frameTiming: frameTimingIn};

  // every pin crosses two flops before any edge logic looks at it
  pts_sync #(
    .WIDTH($bits(pts_pins_s)),
    .RESET_VALUE(PINS_RESET)
  ) u_pinSync (
    .clk(clk),
    .rst(rst),
    .async(pinsAsync),
    .synced(pinsSync)
  );

  // previous synced levels for edge detection
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pinsPrev <= PINS_RESET;
    end else begin
      pinsPrev <= pinsSync;
    end
  end

  assign advRise = pts_rise(pinsSync.advance, pinsPrev.advance);
  assign runRise = pts_rise(pinsSync.run, pinsPrev.run);
  assign runFall = pts_fall(pinsSync.run, pinsPrev.run);

  //////////////////////////////////////////////////////////////////////////
  // role and peer presence

  // role follows the strap level; reset reads secondary so pins stay quiet
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      isPrimary <= 1'b0;
      peerReady <= 1'b0;
    end else begin
      isPrimary <= pinsSync.role;
      peerReady <= pinsSync.role && pinsSync.peerPresent;
    end
  end

  // secondary pulls the presence line high once ready; pulldown otherwise
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      peerPresentOut <= 1'b0;
      peerPresentOe <= 1'b0;
    end else begin
      peerPresentOut <= !isPrimary && selfReady;
      peerPresentOe <= !isPrimary && selfReady;
    end
  end

  // peer chip select is driven only by the primary, idle high
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      peerSerialSelectN <= 1'b1;
      peerSerialSelectOe <= 1'b0;
    end else begin
      peerSerialSelectN <= !(isPrimary && peerSelectReq);
      peerSerialSelectOe <= isPrimary;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // run control: trigger edges and software commands share one flag

  // a stop from either source wins over a start in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      runFlag <= 1'b0;
    end else if (runFall || swStopCmd) begin
      runFlag <= 1'b0;
    end else if (runRise || swStartCmd) begin
      runFlag <= 1'b1;
    end
  end

  assign goNow = runFlag && videoPatternMode && isPrimary;

  //////////////////////////////////////////////////////////////////////////
  // pattern sequencer

  // next state and pattern index
  always_comb begin
    next_state = state;
    next_index = patternIndex;
    unique case (state)
      ST_IDLE: begin
        if (goNow) begin
          next_state = ST_EXPOSE;
          next_index = '0;
        end
      end
      ST_EXPOSE: begin
        if (!goNow) begin
          next_state = ST_IDLE;
        end else if (exposeCnt <= EXPOSE_W'(1)) begin
          next_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (!goNow) begin
          next_state = ST_IDLE;
        end else if (advRise) begin
          next_state = ST_EXPOSE;
          if (patternIndex + 1'b1 >= patternCount) begin
            next_index = '0;
          end else begin
            next_index = patternIndex + 1'b1;
          end
        end
      end
    endcase
  end

  assign startExpose = (next_state == ST_EXPOSE) && (state != ST_EXPOSE);

  // state, index and exposure countdown; a zero length acts as one
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      patternIndex <= '0;
      exposeCnt <= '0;
    end else begin
      state <= next_state;
      patternIndex <= next_index;
      if (startExpose) begin
        exposeCnt <= exposureCycles;
      end else if (exposeCnt != '0) begin
        exposeCnt <= exposeCnt - 1'b1;
      end
    end
  end

  // trigger outputs track the state they describe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      exposureActiveOut <= 1'b0;
      firstPatternOut <= 1'b0;
    end else begin
      exposureActiveOut <= next_state == ST_EXPOSE;
      firstPatternOut <= (next_state == ST_EXPOSE)
                         && (next_index == '0);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // light sources

  // sources lit only while exposing, so a stop darkens them at once
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lampOn <= RGB_OFF;
    end else if (next_state == ST_EXPOSE) begin
      lampOn <= sourceMask;
    end else begin
      lampOn <= RGB_OFF;
    end
  end

  assign redSourceEnable = lampOn.red;
  assign greenSourceEnable = lampOn.green;
  assign blueSourceEnable = lampOn.blue;

  pts_pwm #(.WIDTH(PWM_W)) u_pwmRed (
    .clk(clk),
    .rst(rst),
    .enable(lampOn.red),
    .duty(sourceDuty[LANE_RED]),
    .pwm(redSourcePwm)
  );

  pts_pwm #(.WIDTH(PWM_W)) u_pwmGreen (
    .clk(clk),
    .rst(rst),
    .enable(lampOn.green),
    .duty(sourceDuty[LANE_GREEN]),
    .pwm(greenSourcePwm)
  );

  pts_pwm #(.WIDTH(PWM_W)) u_pwmBlue (
    .clk(clk),
    .rst(rst),
    .enable(lampOn.blue),
    .duty(sourceDuty[LANE_BLUE]),
    .pwm(blueSourcePwm)
  );

  //////////////////////////////////////////////////////////////////////////
  // sequence align line

  // primary pulls the shared line low as the first pattern starts
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      alignCnt <= '0;
    end else if (startExpose && next_index == '0) begin
      alignCnt <= ALIGN_LOAD;
    end else if (alignCnt != '0) begin
      alignCnt <= alignCnt - 1'b1;
    end
  end

  // open drain: drives only low, the pullup makes the high
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sequenceAlignOut <= 1'b0;
      sequenceAlignOe <= 1'b0;
      sequenceRestart <= 1'b0;
    end else begin
      sequenceAlignOut <= 1'b0;
      sequenceAlignOe <= isPrimary && (alignCnt != '0);
      sequenceRestart <= !isPrimary
        && pts_fall(pinsSync.seqAlign, pinsPrev.seqAlign);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // frame timing

  // free-running frame counter, held at zero in the secondary
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      frameCnt <= '0;
    end else if (!isPrimary || frameCnt == FRAME_LAST) begin
      frameCnt <= '0;
    end else begin
      frameCnt <= frameCnt + 1'b1;
    end
  end

  // secondary leaves its output floating; loopback input serves both
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      frameTimingOut <= 1'b0;
      frameTimingOe <= 1'b0;
      frameTick <= 1'b0;
    end else begin
      frameTimingOut <= isPrimary && (frameCnt < FRAME_HIGH);
      frameTimingOe <= isPrimary;
      frameTick <= pts_rise(pinsSync.frameTiming,
                            pinsPrev.frameTiming);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  chk_expose_level: assert property (
    exposureActiveOut == (state == ST_EXPOSE))
    else $error("exposure output disagrees with sequencer");

  chk_run_start: assert property (
    (state == ST_IDLE && goNow) |=> exposureActiveOut && patternIndex == '0)
    else $error("run did not start at first pattern");

  chk_run_stop: assert property (
    runFall |-> ##2 (state == ST_IDLE && !exposureActiveOut))
    else $error("run falling edge did not stop display");

  chk_sw_start: assert property (
    (swStartCmd && !swStopCmd && !runFall) |=> runFlag)
    else $error("software start ignored");

  chk_advance_step: assert property (
    (state == ST_WAIT && goNow && advRise)
    |=> exposureActiveOut && (patternIndex != $past(patternIndex)
        || $past(patternCount) <= INDEX_W'(1)))
    else $error("advance did not step pattern");

  chk_first_pattern: assert property (
    firstPatternOut |-> exposureActiveOut && patternIndex == '0)
    else $error("first pattern flag outside first pattern");

  chk_led_gate: assert property (
    (redSourceEnable || greenSourceEnable || blueSourceEnable)
    |-> exposureActiveOut)
    else $error("source lit outside exposure");

  chk_secondary_quiet: assert property (
    !isPrimary |=> !exposureActiveOut && !firstPatternOut
                   && !redSourceEnable && !frameTimingOe)
    else $error("secondary drove reserved pins");

  chk_select_drive: assert property (
    (isPrimary && peerSelectReq) |=> !peerSerialSelectN && peerSerialSelectOe)
    else $error("peer select not driven");

  chk_peer_flag: assert property (
    peerPresentOe |-> peerPresentOut && !$past(isPrimary))
    else $error("presence driven by primary");

  // a role change may cut a pulse short, so only the primary is held to it
  chk_align_pulse: assert property (
    disable iff (rst || !isPrimary)
    $rose(sequenceAlignOe) |-> sequenceAlignOe [*8])
    else $error("align pulse too short");

  chk_frame_pulse: assert property (
    disable iff (rst || !isPrimary)
    $rose(frameTimingOut)
    |-> frameTimingOut [*8] ##1 frameTimingOut [*2] ##1 !frameTimingOut)
    else $error("frame pulse width wrong");

  cov_start: cover property (state == ST_IDLE ##1 exposureActiveOut);
  cov_wrap: cover property (
    (state == ST_WAIT && advRise && goNow) ##1 firstPatternOut);
  cov_restart: cover property (sequenceRestart);
  cov_frame: cover property (frameTick && isPrimary);

endmodule : pts_io_top

`default_nettype wire

// >>> verification/pts_peer_model.sv
/*
  Behavioural far side: the peer controller and the board wiring between
  the two controllers (presence, shared align line, frame loopback).
  Assumes the bench sets the peer's own drive levels off the clock edge.
*/
`timescale 1ns/100ps
`default_nettype none

module pts_peer_model (
  input wire logic dutPresentOut,
  input wire logic dutPresentOe,
  input wire logic dutAlignOut,
  input wire logic dutAlignOe,
  input wire logic dutFrameOut,
  input wire logic dutFrameOe,
  input wire logic peerPresentDrive,
  input wire logic peerAlignPull,
  input wire logic peerFrameDrive,
  output logic presenceWire,
  output logic alignWire,
  output logic frameWire
);
  //////////////////////////////////////////////////////////////////////
  // pulldown on presence, so only an active drive reads high
  assign presenceWire = (dutPresentOe & dutPresentOut) | peerPresentDrive;
  // open-drain align line with pullup; either side may pull
  assign alignWire = ~((dutAlignOe & ~dutAlignOut) | peerAlignPull);
  // primary output loops back; a secondary dut hears the peer
  assign frameWire = dutFrameOe ? dutFrameOut : peerFrameDrive;
endmodule : pts_peer_model
`default_nettype wire

// >>> verification/tb_pts_io_top.sv
/*
  Self-checking bench for the pattern trigger and peer sync pin logic.
  Assumes a 25 MHz clock, inputs driven on the falling edge and the
  frame period shortened to 40 clocks.
*/
`timescale 1ns/100ps
`default_nettype none

module tb_pts_io_top;
  import pts_pkg::*;

  typedef struct {pts_rgb_s mask; int expo; int cnt; int len;} pts_row_s;

  logic clk, rst, patternAdvanceIn, patternRunIn, roleSelect;
  logic videoPatternMode, swStartCmd, swStopCmd, selfReady, peerSelectReq;
  logic [7:0] patternCount;
  logic [23:0] exposureCycles;
  pts_rgb_s sourceMask;
  pts_duty_t sourceDuty;
  logic exposureActiveOut, firstPatternOut, isPrimary, peerReady;
  logic redSourcePwm, greenSourcePwm, blueSourcePwm, frameTick;
  logic redSourceEnable, greenSourceEnable, blueSourceEnable;
  logic peerPresentOut, peerPresentOe, peerSerialSelectN, peerSerialSelectOe;
  logic sequenceAlignOut, sequenceAlignOe, frameTimingOut, frameTimingOe;
  logic sequenceRestart, presenceWire, alignWire, frameWire;
  logic peerPresentDrive, peerAlignPull, peerFrameDrive;
  logic [7:0] patternIndex;
  logic [2:0] enables;
  logic [5:0] watch;
  int errors, totalChecks, c, idx;
  // ordinary cases: mask, exposure setting, count, expected length
  pts_row_s rows[5] = '{'{3'h4, 1, 1, 1}, '{3'h2, 3, 2, 3},
    '{3'h1, 5, 3, 5}, '{3'h7, 2, 3, 2}, '{3'h3, 0, 1, 1}};

  //////////////////////////////////////////////////////////////////////
  pts_io_top #(.FRAME_CYCLES(40)) dut (.clk, .rst, .patternAdvanceIn,
    .patternRunIn, .roleSelect, .peerPresentIn(presenceWire),
    .sequenceAlignIn(alignWire), .frameTimingIn(frameWire),
    .videoPatternMode, .swStartCmd, .swStopCmd, .selfReady, .peerSelectReq,
    .patternCount, .exposureCycles, .sourceMask, .sourceDuty,
    .exposureActiveOut, .firstPatternOut, .redSourcePwm, .greenSourcePwm,
    .blueSourcePwm, .redSourceEnable, .greenSourceEnable, .blueSourceEnable,
    .peerPresentOut, .peerPresentOe, .peerSerialSelectN, .peerSerialSelectOe,
    .sequenceAlignOut, .sequenceAlignOe, .frameTimingOut, .frameTimingOe,
    .isPrimary, .peerReady, .patternIndex, .sequenceRestart, .frameTick);

  pts_peer_model peer (.dutPresentOut(peerPresentOut),
    .dutPresentOe(peerPresentOe), .dutAlignOut(sequenceAlignOut),
    .dutAlignOe(sequenceAlignOe), .dutFrameOut(frameTimingOut),
    .dutFrameOe(frameTimingOe), .peerPresentDrive, .peerAlignPull,
    .peerFrameDrive, .presenceWire, .alignWire, .frameWire);

  // grouped views for compact comparisons and pulse counting
  assign enables = {redSourceEnable, greenSourceEnable, blueSourceEnable};
  assign watch = {frameTimingOut, frameTick, sequenceRestart,
    redSourcePwm, greenSourcePwm, blueSourcePwm};

  // free-running 25 MHz clock
  always #20 clk = ~clk;

  //////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick

  // bounded wait, so a missing exposure cannot hang the run
  task automatic waitExpo();
    int n;
    n = 0;
    while (exposureActiveOut !== 1'b1 && n < 40) begin
      n++;
      @(negedge clk);
    end
    check(exposureActiveOut, 1);
  endtask : waitExpo

  task automatic measure(output int len);
    len = 0;
    while (exposureActiveOut === 1'b1 && len < 300) begin
      len++;
      @(negedge clk);
    end
  endtask : measure

  task automatic countOver(input int sel, input int n, output int cnt);
    cnt = 0;
    repeat (n) begin
      @(negedge clk);
      cnt += (watch[sel] === 1'b1);
    end
  endtask : countOver

  task automatic conclude();
    $display("checks=%0d errors=%0d", totalChecks, errors);
    if (errors == 0 && totalChecks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude

  //////////////////////////////////////////////////////////////////////
  // watchdog: whole run is about 1100 clocks
  initial begin
    #(40 * 20000);
    errors++;
    conclude();
  end

  // main sequence
  initial begin
    {clk, patternAdvanceIn, patternRunIn, swStartCmd, swStopCmd} = '0;
    {selfReady, peerSelectReq, peerPresentDrive, peerAlignPull} = '0;
    {rst, roleSelect, videoPatternMode, peerFrameDrive} = 4'he;
    {patternCount, exposureCycles, sourceMask} = '0;
    sourceDuty = {8'h40, 8'h80, 8'h01};
    tick(2);
    check(peerSerialSelectN, 1);
    check({exposureActiveOut, enables}, 0);
    tick(4);
    rst = 0;
    tick(6);
    check({isPrimary, frameTimingOe}, 2'h3);
    // frame pulses loop back into the frame input
    countOver(5, 40, c);
    check(c, 10);
    countOver(4, 40, c);
    check(c, 1);
    // one full pwm period per lane, inside a long all-colour exposure
    sourceMask = 3'h7;
    exposureCycles = 24'h400;
    swStartCmd = 1;
    tick(1);
    swStartCmd = 0;
    waitExpo();
    foreach (sourceDuty[i]) begin
      countOver(i, 256, c);
      check(c, sourceDuty[i]);
    end
    swStopCmd = 1;
    tick(1);
    swStopCmd = 0;
    tick(2);
    // row loop: start, every advance with wrap, exposure length
    foreach (rows[i]) begin
      sourceMask = rows[i].mask;
      exposureCycles = 24'(rows[i].expo);
      patternCount = 8'(rows[i].cnt);
      swStartCmd = 1;
      tick(1);
      swStartCmd = 0;
      for (int k = 0; k <= rows[i].cnt; k++) begin
        if (k > 0) begin
          patternAdvanceIn = 1;
          tick(2);
          patternAdvanceIn = 0;
        end
        waitExpo();
        idx = k % rows[i].cnt;
        check(patternIndex, 32'(idx));
        check(firstPatternOut, 32'(idx == 0));
        check(enables, rows[i].mask);
        measure(c);
        // align pulse shows on the wire one clock after exposure starts
        if (idx == 0) check(alignWire, 0);
        check(c, rows[i].len);
        check(enables, 0);
      end
      swStopCmd = 1;
      tick(1);
      swStopCmd = 0;
      tick(2);
    end
    // pin run: sync delay, advance dropped mid-exposure, stop by pin
    exposureCycles = 24'h14;
    patternCount = 8'h02;
    patternRunIn = 1;
    tick(2);
    check(exposureActiveOut, 0);
    waitExpo();
    patternAdvanceIn = 1;
    tick(2);
    patternAdvanceIn = 0;
    measure(c);
    tick(8);
    check({exposureActiveOut, patternIndex}, 0);
    patternAdvanceIn = 1;
    tick(2);
    patternAdvanceIn = 0;
    waitExpo();
    patternRunIn = 0;
    tick(7);
    check(exposureActiveOut, 0);
    // stop beats start; software stop mid-exposure; mode refusal
    {swStartCmd, swStopCmd} = 2'h3;
    tick(1);
    {swStartCmd, swStopCmd} = 2'h0;
    tick(6);
    check(exposureActiveOut, 0);
    swStartCmd = 1;
    tick(1);
    swStartCmd = 0;
    waitExpo();
    swStopCmd = 1;
    tick(1);
    swStopCmd = 0;
    tick(3);
    check(exposureActiveOut, 0);
    videoPatternMode = 0;
    swStartCmd = 1;
    tick(1);
    swStartCmd = 0;
    tick(6);
    check(exposureActiveOut, 0);
    videoPatternMode = 1;
    // presence from a secondary peer, then the peer chip select
    peerPresentDrive = 1;
    tick(5);
    check(peerReady, 1);
    peerPresentDrive = 0;
    tick(5);
    check(peerReady, 0);
    peerSelectReq = 1;
    tick(1);
    check({peerSerialSelectN, peerSerialSelectOe}, 2'h1);
    // secondary role: pins idle, presence driven, sync lines heard
    roleSelect = 0;
    peerFrameDrive = 0;
    tick(5);
    check({isPrimary, frameTimingOe}, 0);
    check(peerSerialSelectN, 1);
    swStartCmd = 1;
    tick(1);
    swStartCmd = 0;
    tick(6);
    check({exposureActiveOut, firstPatternOut, enables}, 0);
    selfReady = 1;
    tick(2);
    check({peerPresentOe, presenceWire}, 2'h3);
    peerAlignPull = 1;
    countOver(3, 8, c);
    check(c, 1);
    peerFrameDrive = 1;
    countOver(4, 8, c);
    check(c, 1);
    conclude();
  end
endmodule : tb_pts_io_top
`default_nettype wire
